// >>> contact_input_assertions.sv
// Checker bound to every contact_input_logic.
// Assumes outputs lag a pin by three edges, the analog hold by four.
`timescale 1ns/1ps
`include "contact_input_defs.svh"

module contact_input_assertions #(
    parameter int N_IN = 8,
    parameter int MS_W = 16
) (
    input wire logic                         clk,
    input wire logic                         rst,
    input wire logic [N_IN-1:0]              contactIn,
    input wire logic [N_IN-1:0][7:0]         inputFunctionSelect,
    input wire logic [1:0]                   controlModeSelect,
    input wire logic [MS_W-1:0]              switchWaitTime,
    input wire contact_input_pkg::pid_ctrl_t pidCtrl,
    input wire contact_input_pkg::run_ctrl_t runCtrl,
    input wire contact_input_pkg::ref_ctrl_t refCtrl,
    input wire logic                         thermostatAlarm,
    input wire logic                         torqueControl,
    input wire logic                         settingConflictError
);
    localparam int NC = 13;
    localparam logic [7:0] CODE [NC] = '{`FC_PID_IRESET, `FC_PID_IHOLD, `FC_THERMO,
        `FC_PID_SIGN, `FC_FWD2W, `FC_REV2W, `FC_RUN2W2, `FC_DIR2W2, `FC_SRCH1, `FC_SRCH2,
        `FC_ENABLE1, `FC_ENABLE2, `FC_SPDTRQ};
    logic [NC-1:0] closed;
    logic [NC-1:0] used;
    logic          enableOn;
    logic          conflict;
    logic          warm;
    logic [2:0]    settle_q;
    logic [2:0]    settle_d;

    // Per code: any terminal closed, any terminal assigned
    always_comb begin
        closed = '0;
        used = '0;
        for (int i = 0; i < NC; i++) begin
            for (int k = 0; k < N_IN; k++) begin
                if (inputFunctionSelect[k] == CODE[i]) begin
                    closed[i] = closed[i] | contactIn[k];
                    used[i] = 1'b1;
                end
            end
        end
    end
    assign enableOn = closed[10] | closed[11];
    assign conflict = (used[8] & used[9]) | ((used[4] | used[5]) & (used[6] | used[7]));
    // Past values mean nothing until the synchronisers refill after reset
    always_comb begin
        settle_d = (settle_q == 3'h7) ? settle_q : settle_q + 3'h1;
    end
    always_ff @(posedge clk) begin
        settle_q <= rst ? 3'h0 : settle_d;
    end
    assign warm = (settle_q >= 3'h6);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_reset_follows: assert property (warm |-> pidCtrl.integralReset == $past(closed[0], 3))
        else $error("integral reset wrong");
    a_hold_follows: assert property (warm && !$past(closed[0], 3) |->
        pidCtrl.integralHold == $past(closed[1], 3))
        else $error("integral hold wrong");
    a_thermo_open: assert property (warm && used[2] |->
        thermostatAlarm == !$past(closed[2], 3))
        else $error("thermostat alarm wrong");
    a_sign_follows: assert property (warm |-> pidCtrl.inputInvert == $past(closed[3], 3))
        else $error("input invert wrong");
    a_both_fault: assert property (warm && $past(closed[4], 3) && $past(closed[5], 3) |->
        runCtrl.externalFault && !runCtrl.runFwd && !runCtrl.runRev)
        else $error("fault missing");
    a_enable_blocks: assert property (warm && (used[10] | used[11]) && !$past(enableOn, 3) |->
        runCtrl.driveDisabledIndication && !runCtrl.runFwd && !runCtrl.runRev)
        else $error("run while disabled");
    a_conflict_flag: assert property (conflict == $past(conflict) &&
        conflict == $past(conflict, 3) |-> settingConflictError == conflict)
        else $error("conflict flag wrong");
    a_hold_window: assert property (warm && used[12] && switchWaitTime != '0 &&
        $past(closed[12], 4) != $past(closed[12], 5) |-> refCtrl.holdAnalog [*8])
        else $error("analog hold missing");
    a_torque_mode: assert property (warm && used[12] &&
        controlModeSelect == `CTRL_MODE_SWITCHABLE |-> torqueControl == $past(closed[12], 3))
        else $error("torque control wrong");

    cp_fault: cover property (runCtrl.externalFault);
    cp_disabled: cover property (runCtrl.driveDisabledIndication);
    cp_hold: cover property (refCtrl.holdAnalog);
endmodule // contact_input_assertions

bind contact_input_logic contact_input_assertions #(.N_IN(N_IN), .MS_W(MS_W)) chk (
    .clk, .rst, .contactIn, .inputFunctionSelect, .controlModeSelect, .switchWaitTime,
    .pidCtrl, .runCtrl, .refCtrl, .thermostatAlarm, .torqueControl, .settingConflictError);

// >>> contact_input_defs.svh
// Function codes, setting values and timing for the contact input logic.
// Assumes a single 200 MHz clock; included by the package and the modules.
// Behaviour
// R1 - Code 30 input closed forces the PID integral to zero.
// R2 - Code 31 input freezes the integral; release resumes from the held value.
// R3 - Code 32 input is the fourth multi-step select bit for the upper speeds.
// R4 - Code 33 N.C. thermostat contact open raises the thermostat alarm.
// R5 - Code 34 cancels the PID soft starter, bypassing the PID ramp time.
// R6 - Code 35 input inverts the sign of the PID input.
// R7 - Sequence one: code 40 runs forward, code 41 runs reverse.
// R8 - Codes 40 and 41 both closed declare an external fault.
// R9 - Sequence two: code 42 closed runs in the chosen direction, open stops.
// R10 - Code 43 closed selects forward, open selects reverse.
// R11 - Codes 44, 45, 46 each add their offset frequency to the reference.
// R12 - Code 60 while stopped starts DC braking; run or jog ends it.
// R13 - Codes 61 or 62 enable speed search even when start search is off.
// R14 - Both speed search codes assigned at once flag the setting conflict error.
// R15 - In V/f control, code 63 closed applies field weakening.
// R16 - Code 67 runs a looped-back serial self-test.
// R17 - Codes 6A or 70 block run until closed; open shows drive disabled.
// R18 - A run command held before enable closes needs a fresh run command.
// R19 - Enable opening while running stops by the configured stop method.
// R20 - Code 71 closed selects torque control, open speed; only with mode 0.
// R21 - During the switch wait time after code 71 changes, hold analog references.
// R22 - Equipment finishes reference changes within the switch wait time.
// R23 - Each terminal's function code routes that input to its behaviour.
// R24 - Assigning both 2-wire sequence schemes together is a setting conflict.
`ifndef CONTACT_INPUT_DEFS_SVH
`define CONTACT_INPUT_DEFS_SVH

`define FC_PID_IRESET    8'h30
`define FC_PID_IHOLD     8'h31
`define FC_STEP4         8'h32
`define FC_THERMO        8'h33
`define FC_SOFT_CANCEL   8'h34
`define FC_PID_SIGN      8'h35
`define FC_FWD2W         8'h40
`define FC_REV2W         8'h41
`define FC_RUN2W2        8'h42
`define FC_DIR2W2        8'h43
`define FC_OFS1          8'h44
`define FC_OFS2          8'h45
`define FC_OFS3          8'h46
`define FC_DCBRAKE       8'h60
`define FC_SRCH1         8'h61
`define FC_SRCH2         8'h62
`define FC_FIELDWEAK     8'h63
`define FC_COMMTEST      8'h67
`define FC_ENABLE1       8'h6A
`define FC_ENABLE2       8'h70
`define FC_SPDTRQ        8'h71

`define CTRL_MODE_SWITCHABLE 2'h0
`define SEARCH_START_OFF     1'h0

`define CLK_MHZ          200
`define CYCLES_PER_MS    (`CLK_MHZ * 1000)
`define TEST_PATTERN     8'hA5

`endif

// >>> contact_input_function_logic_test.sv
// Self-checking bench, sixteen terminals.
// Assumes the checker is bound and the partner drives contacts and loopback.
`timescale 1ns/1ps

module contact_input_function_logic_test;
    localparam int N_IN = 16;
    localparam int MS_W = 16;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic runCmd = 1'b0, jogCmd = 1'b0, driveRunning = 1'b0, loopBreak = 1'b0;
    logic vfControl = 1'b1, speedSearchAtStartSelect = 1'b0;
    logic [1:0] controlModeSelect = 2'h0;
    logic [MS_W-1:0] switchWaitTime = 16'h0001;
    logic [N_IN-1:0] levels = '0, contactIn;
    logic [N_IN-1:0][7:0] inputFunctionSelect, sel;
    logic serialRx, serialTx, thermostatAlarm, dcBrake, speedSearchEnable, fieldWeaken;
    logic torqueControl, settingConflictError, commTestBusy, commTestPass, commTestFail;
    contact_input_pkg::pid_ctrl_t pidCtrl;
    contact_input_pkg::run_ctrl_t runCtrl;
    contact_input_pkg::ref_ctrl_t refCtrl;
    logic [14:0] obs;
    int badCount = 0, compares = 0;
    // Terminal 15 down to 0
    localparam logic [N_IN-1:0][7:0] BASE = {8'h71, 8'h6A, 8'h63, 8'h61, 8'h60, 8'h46, 8'h45,
        8'h44, 8'h41, 8'h40, 8'h35, 8'h34, 8'h33, 8'h32, 8'h31, 8'h30};
    // Contacts, then {pid, ref select, thermo, weaken, fault, fwd, rev, brake, search}
    localparam logic [30:0] ROWS [12] = '{{16'h4008, 15'h0000}, {16'h4009, 15'h4000},
        {16'h400A, 15'h2000}, {16'h4038, 15'h1800}, {16'h470C, 15'h0780},
        {16'h4000, 15'h0040}, {16'h4048, 15'h0008}, {16'h4088, 15'h0004},
        {16'h40C8, 15'h0010}, {16'h4808, 15'h0002}, {16'h7008, 15'h0021},
        {16'h4008, 15'h0000}};

    assign obs = {pidCtrl, refCtrl[4:1], thermostatAlarm, fieldWeaken, runCtrl.externalFault,
        runCtrl.runFwd, runCtrl.runRev, dcBrake, speedSearchEnable};

    contact_partner #(.N_IN(N_IN)) partner (.levels, .loopBreak, .serialTx, .contactIn,
        .serialRx);
    contact_input_logic #(.N_IN(N_IN), .MS_W(MS_W)) DUT (.clk, .rst, .contactIn,
        .inputFunctionSelect, .runCmd, .jogCmd, .driveRunning, .vfControl, .controlModeSelect,
        .speedSearchAtStartSelect, .switchWaitTime, .serialRx, .serialTx, .pidCtrl, .runCtrl,
        .refCtrl, .thermostatAlarm, .dcBrake, .speedSearchEnable, .fieldWeaken, .torqueControl,
        .settingConflictError, .commTestBusy, .commTestPass, .commTestFail);

    always #2.5 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        compares++;
        if (seen !== want) begin
            badCount++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask

    task automatic drive(input logic [N_IN-1:0] value);
        @(negedge clk);
        levels = value;
        repeat (4) @(negedge clk);
    endtask

    task automatic setup(input logic [N_IN-1:0][7:0] value);
        @(negedge clk);
        inputFunctionSelect = value;
        repeat (4) @(negedge clk);
    endtask

    task automatic testDone();
        $display("Comparisons %0d, mismatches %0d", compares, badCount);
        if (badCount == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic selfTest(input logic brk, input logic [1:0] want);
        drive(16'h4008);
        loopBreak = brk;
        drive(16'h400C);
        check(32'(commTestBusy), 32'h1, "comm busy");
        for (int n = 0; n < 400 && !(commTestPass === 1'b1 || commTestFail === 1'b1); n++) begin
            @(negedge clk);
        end
        check(32'({commTestPass, commTestFail}), 32'(want), "comm test verdict");
    endtask

    initial begin
        inputFunctionSelect = BASE;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        check(32'({serialTx, obs}), 32'h8000, "state after reset");
        for (int i = 0; i < 12; i++) begin
            drive(ROWS[i][30:15]);
            check(32'(obs), 32'(ROWS[i][14:0]), "row outputs");
        end
        driveRunning = 1'b1;
        drive(16'h0048);
        check(32'({runCtrl.runFwd, runCtrl.driveDisabledIndication}), 32'h1, "enable open");
        check(32'(runCtrl.stopRequest), 32'h1, "disabled stop");
        drive(16'h4048);
        check(32'(runCtrl.runFwd), 32'h0, "held run");
        drive(16'h4008);
        drive(16'h4048);
        check(32'(runCtrl.runFwd), 32'h1, "fresh run");
        drive(16'h0048);
        check(32'({runCtrl.runFwd, runCtrl.stopRequest}), 32'h1, "enable lost");
        driveRunning = 1'b0;
        drive(16'h4808);
        check(32'(dcBrake), 32'h1, "brake");
        jogCmd = 1'b1;
        repeat (4) @(negedge clk);
        check(32'(dcBrake), 32'h0, "jog ends brake");
        jogCmd = 1'b0;
        drive(16'h4008);
        sel = BASE;
        sel[6] = 8'h42;
        sel[7] = 8'h43;
        setup(sel);
        check(32'(settingConflictError), 32'h0, "scheme two");
        drive(16'h40C8);
        check(32'({runCtrl.runFwd, runCtrl.runRev}), 32'h2, "run forward");
        drive(16'h4048);
        check(32'({runCtrl.runFwd, runCtrl.runRev}), 32'h1, "run reverse");
        drive(16'h4008);
        check(32'({runCtrl.runFwd, runCtrl.runRev}), 32'h0, "run stops");
        sel[7] = 8'h41;
        setup(sel);
        check(32'(settingConflictError), 32'h1, "both schemes");
        sel = BASE;
        sel[13] = 8'h62;
        setup(sel);
        check(32'(settingConflictError), 32'h1, "both searches");
        sel[13] = 8'h63;
        sel[2] = 8'h67;
        setup(sel);
        check(32'(settingConflictError), 32'h0, "no conflict");
        selfTest(1'b0, 2'h2);
        selfTest(1'b1, 2'h1);
        loopBreak = 1'b0;
        drive(16'h4008);
        setup(BASE);
        drive(16'hC008);
        check(32'({torqueControl, refCtrl.holdAnalog}), 32'h3, "torque and hold");
        repeat (1000) @(negedge clk);
        check(32'(refCtrl.holdAnalog), 32'h1, "hold in wait");
        rst = 1'b1;
        levels = 16'h4008;
        repeat (4) @(negedge clk);
        check(32'({serialTx, torqueControl, refCtrl.holdAnalog}), 32'h4, "second reset");
        rst = 1'b0;
        testDone();
    end

    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        testDone();
    end
endmodule // contact_input_function_logic_test

// >>> contact_input_logic.sv
// Decodes and sequences the drive's contact input functions.
// Assumes async contact pins; codes and settings are static on clk.
`timescale 1ns/1ps
`include "contact_input_defs.svh"

module contact_input_logic #(
    parameter int N_IN = 8,
    parameter int MS_W = 16
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [N_IN-1:0]          contactIn,
    input  wire logic [N_IN-1:0][7:0]     inputFunctionSelect,

    input  wire logic                     runCmd,
    input  wire logic                     jogCmd,
    input  wire logic                     driveRunning,
    input  wire logic                     vfControl,
    input  wire logic [1:0]               controlModeSelect,
    input  wire logic                     speedSearchAtStartSelect,
    input  wire logic [MS_W-1:0]          switchWaitTime,
    input  wire logic                     serialRx,

    output logic                          serialTx,

    output contact_input_pkg::pid_ctrl_t  pidCtrl,
    output contact_input_pkg::run_ctrl_t  runCtrl,
    output contact_input_pkg::ref_ctrl_t  refCtrl,
    output logic                          thermostatAlarm,
    output logic                          dcBrake,
    output logic                          speedSearchEnable,
    output logic                          fieldWeaken,
    output logic                          torqueControl,
    output logic                          settingConflictError,
    output logic                          commTestBusy,
    output logic                          commTestPass,
    output logic                          commTestFail
);
    logic [N_IN-1:0] sync1_q, sync2_q;
    logic            runSync1_q, runSync2_q;
    logic            jogSync1_q, jogSync2_q;
    logic            rxSync1_q, rxSync2_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q    <= '0;
            sync2_q    <= '0;
            runSync1_q <= 1'b0;
            runSync2_q <= 1'b0;
            jogSync1_q <= 1'b0;
            jogSync2_q <= 1'b0;

            rxSync1_q  <= 1'b1;
            rxSync2_q  <= 1'b1;
        end else begin
            sync1_q    <= contactIn;
            sync2_q    <= sync1_q;
            runSync1_q <= runCmd;
            runSync2_q <= runSync1_q;
            jogSync1_q <= jogCmd;
            jogSync2_q <= jogSync1_q;

            rxSync1_q  <= serialRx;
            rxSync2_q  <= rxSync1_q;
        end
    end

    // Bit 1: some terminal has the code; bit 0: one of those is closed
    function automatic logic [1:0] lookup(input logic [N_IN-1:0] lvl,
                                          input logic [7:0] code);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < N_IN; i++) begin
            if (inputFunctionSelect[i] == code) begin
                r[1] = 1'b1;
                r[0] = r[0] | lvl[i];
            end
        end
        return r;
    endfunction

    logic [1:0] fReset, fHold, fStep4, fThermo, fSoft, fSign;
    logic [1:0] fFwd, fRev, fRun2, fDir2;
    logic [1:0] fOfs1, fOfs2, fOfs3, fDcb;
    logic [1:0] fSr1, fSr2, fFw, fTest;
    logic [1:0] fEn1, fEn2, fSt;

    always_comb begin
        fReset  = lookup(sync2_q, `FC_PID_IRESET);   // R23
        fHold   = lookup(sync2_q, `FC_PID_IHOLD);
        fStep4  = lookup(sync2_q, `FC_STEP4);
        fThermo = lookup(~sync2_q, `FC_THERMO);
        fSoft   = lookup(sync2_q, `FC_SOFT_CANCEL);
        fSign   = lookup(sync2_q, `FC_PID_SIGN);

        fFwd    = lookup(sync2_q, `FC_FWD2W);
        fRev    = lookup(sync2_q, `FC_REV2W);
        fRun2   = lookup(sync2_q, `FC_RUN2W2);
        fDir2   = lookup(sync2_q, `FC_DIR2W2);

        fOfs1   = lookup(sync2_q, `FC_OFS1);
        fOfs2   = lookup(sync2_q, `FC_OFS2);
        fOfs3   = lookup(sync2_q, `FC_OFS3);

        fDcb    = lookup(sync2_q, `FC_DCBRAKE);

        fSr1    = lookup(sync2_q, `FC_SRCH1);
        fSr2    = lookup(sync2_q, `FC_SRCH2);
        fFw     = lookup(sync2_q, `FC_FIELDWEAK);
        fTest   = lookup(sync2_q, `FC_COMMTEST);

        fEn1    = lookup(sync2_q, `FC_ENABLE1);
        fEn2    = lookup(sync2_q, `FC_ENABLE2);
        fSt     = lookup(sync2_q, `FC_SPDTRQ);
    end

    // Run enable and sequencing
    logic enablePresent, enableClosed, conflict;
    logic armed_q, armed_d, stPrev_q;
    logic brake_q, brake_d;
    contact_input_pkg::run_ctrl_t runCtrl_d;
    contact_input_pkg::pid_ctrl_t pidCtrl_d;
    contact_input_pkg::ref_ctrl_t refCtrl_d;
    logic wantFwd, wantRev, runReq;
    logic torque_d, holdBusy, stChange;

    always_comb begin
        enablePresent = fEn1[1] | fEn2[1];
        enableClosed  = (!fEn1[1] | fEn1[0]) & (!fEn2[1] | fEn2[0]);

        conflict      = (fSr1[1] & fSr2[1])                                   // R14
                      | ((fFwd[1] | fRev[1]) & (fRun2[1] | fDir2[1]));        // R24

        wantFwd = 1'b0;
        wantRev = 1'b0;
        if (fFwd[1] | fRev[1]) begin
            wantFwd = fFwd[0] & !fRev[0];                                     // R7
            wantRev = fRev[0] & !fFwd[0];
        end else if (fRun2[1]) begin
            wantFwd = fRun2[0] & fDir2[0];                                    // R9 R10
            wantRev = fRun2[0] & !fDir2[0];
        end else begin
            wantFwd = runSync2_q;
        end

        // A run already held when enable closes must drop before it counts
        runReq  = wantFwd | wantRev;
        armed_d = enableClosed & (armed_q | !runReq | !enablePresent);    // R17 R18 R19

        runCtrl_d.externalFault = fFwd[0] & fRev[0];                          // R8
        runCtrl_d.driveDisabledIndication = enablePresent & !enableClosed;    // R17
        runCtrl_d.runFwd = wantFwd & armed_d & enableClosed & !conflict;
        runCtrl_d.runRev = wantRev & armed_d & enableClosed & !conflict;
        runCtrl_d.stopRequest = driveRunning & !enableClosed;                 // R19

        pidCtrl_d.integralReset   = fReset[0];                                // R1
        pidCtrl_d.integralHold    = fHold[0] & !fReset[0];                    // R2
        pidCtrl_d.softStartCancel = fSoft[0];                                 // R5
        pidCtrl_d.inputInvert     = fSign[0];                                 // R6

        refCtrl_d.stepSelect4 = fStep4[0];                                    // R3
        refCtrl_d.offsetOne   = fOfs1[0];                                     // R11
        refCtrl_d.offsetTwo   = fOfs2[0];
        refCtrl_d.offsetThree = fOfs3[0];
        refCtrl_d.holdAnalog  = holdBusy;                                     // R21 R22

        brake_d = brake_q;
        if (runSync2_q | jogSync2_q | driveRunning | !fDcb[0]) begin
            brake_d = 1'b0;                                                   // R12
        end else if (fDcb[0] & !driveRunning & !brake_q) begin
            brake_d = 1'b1;
        end

        torque_d = fSt[1] & (controlModeSelect == `CTRL_MODE_SWITCHABLE) & fSt[0];  // R20
        stChange = fSt[1] & (fSt[0] != stPrev_q);
    end

    switch_wait_timer #(
        .MS_W (MS_W)
    ) u_wait (
        .clk    (clk),
        .rst    (rst),
        .start  (stChange),
        .waitMs (switchWaitTime),
        .busy   (holdBusy)
    );

    // Serial loopback self-test
    contact_input_pkg::test_state_t tst_q, tst_d;
    logic [3:0]  bitIdx_q, bitIdx_d;
    logic [15:0] tmo_q, tmo_d;
    logic        mism_q, mism_d, tx_d;
    logic        pass_d, fail_d;
    logic [9:0]  frame;

    always_comb begin
        frame    = {1'b1, `TEST_PATTERN, 1'b0};
        tst_d    = tst_q;
        bitIdx_d = bitIdx_q;
        tmo_d    = tmo_q;
        mism_d   = mism_q;

        tx_d     = 1'b1;
        pass_d   = commTestPass;
        fail_d   = commTestFail;

        case (tst_q)
            contact_input_pkg::TEST_IDLE: begin
                if (fTest[0]) begin
                    tst_d    = contact_input_pkg::TEST_SEND;                  // R16
                    bitIdx_d = 4'h0;
                    mism_d   = 1'b0;
                    pass_d   = 1'b0;
                    fail_d   = 1'b0;
                end
            end

            contact_input_pkg::TEST_SEND: begin
                tx_d     = frame[bitIdx_q];
                tst_d    = contact_input_pkg::TEST_WAIT;
                tmo_d    = 16'h0000;
            end

            contact_input_pkg::TEST_WAIT: begin
                tx_d  = frame[bitIdx_q];
                tmo_d = tmo_q + 16'h0001;
                if (tmo_q >= 16'h0002) begin
                    mism_d = mism_q | (rxSync2_q != frame[bitIdx_q]);         // R16
                    if (bitIdx_q == 4'h9) begin
                        tst_d = contact_input_pkg::TEST_DONE;
                    end else begin
                        bitIdx_d = bitIdx_q + 4'h1;
                        tst_d    = contact_input_pkg::TEST_SEND;
                    end
                end
            end

            contact_input_pkg::TEST_DONE: begin
                pass_d = !mism_q;
                fail_d = mism_q;
                if (!fTest[0]) begin
                    tst_d = contact_input_pkg::TEST_IDLE;
                end
            end

            default: begin
                tst_d = contact_input_pkg::TEST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            armed_q              <= 1'b0;
            brake_q              <= 1'b0;
            stPrev_q             <= 1'b0;

            runCtrl              <= '0;
            pidCtrl              <= '0;
            refCtrl              <= '0;

            thermostatAlarm      <= 1'b0;
            dcBrake              <= 1'b0;
            speedSearchEnable    <= 1'b0;
            fieldWeaken          <= 1'b0;
            torqueControl        <= 1'b0;
            settingConflictError <= 1'b0;

            tst_q                <= contact_input_pkg::TEST_IDLE;
            bitIdx_q             <= 4'h0;
            tmo_q                <= 16'h0000;
            mism_q               <= 1'b0;
            serialTx             <= 1'b1;
            commTestBusy         <= 1'b0;
            commTestPass         <= 1'b0;
            commTestFail         <= 1'b0;
        end else begin
            armed_q              <= armed_d;
            brake_q              <= brake_d;
            stPrev_q             <= fSt[0];

            runCtrl              <= runCtrl_d;
            pidCtrl              <= pidCtrl_d;
            refCtrl              <= refCtrl_d;

            thermostatAlarm      <= fThermo[0];                                                // R4
            dcBrake              <= brake_d;                                                   // R12
            speedSearchEnable    <= (speedSearchAtStartSelect != `SEARCH_START_OFF)
                                    | fSr1[0] | fSr2[0];                                       // R13
            fieldWeaken          <= vfControl & fFw[0];                                        // R15
            torqueControl        <= torque_d;                                                  // R20
            settingConflictError <= conflict;                                                  // R14 R24

            tst_q                <= tst_d;
            bitIdx_q             <= bitIdx_d;
            tmo_q                <= tmo_d;
            mism_q               <= mism_d;
            serialTx             <= tx_d;
            commTestBusy         <= (tst_d != contact_input_pkg::TEST_IDLE)
                                    & (tst_d != contact_input_pkg::TEST_DONE);
            commTestPass         <= pass_d;
            commTestFail         <= fail_d;
        end
    end
endmodule // contact_input_logic

// >>> contact_input_pkg.sv
// Types shared by the contact input function logic.
// Assumes contact_input_defs.svh is on the include path.
`include "contact_input_defs.svh"

package contact_input_pkg;

    typedef struct packed {
        logic integralReset;
        logic integralHold;
        logic softStartCancel;
        logic inputInvert;
    } pid_ctrl_t;

    typedef struct packed {
        logic runFwd;
        logic runRev;
        logic externalFault;
        logic driveDisabledIndication;
        logic stopRequest;
    } run_ctrl_t;

    typedef struct packed {
        logic stepSelect4;
        logic offsetOne;
        logic offsetTwo;
        logic offsetThree;
        logic holdAnalog;
    } ref_ctrl_t;

    typedef enum logic [3:0] {
        TEST_IDLE = 4'h1,
        TEST_SEND = 4'h2,
        TEST_WAIT = 4'h4,
        TEST_DONE = 4'h8
    } test_state_t;

endpackage

// >>> contact_partner.sv
// Far side of the terminals: dry switch contacts and the serial loopback wire.
// Assumes the bench sets levels; a broken loop corrupts the echo.
`timescale 1ns/1ps

module contact_partner #(
    parameter int N_IN = 8
) (
    input wire logic [N_IN-1:0] levels,
    input wire logic            loopBreak,
    input wire logic            serialTx,
    output logic [N_IN-1:0]     contactIn,
    output logic                serialRx
);
    // Switch changes, speed/torque included, settle before the pin is read
    assign contactIn = levels;
    // Transmit wired to receive; a broken loop inverts every echoed bit
    assign serialRx = loopBreak ? ~serialTx : serialTx;
endmodule // contact_partner

// >>> switch_wait_timer.sv
// Counts the speed/torque switch wait time in milliseconds.
// Assumes a 200 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "contact_input_defs.svh"

module switch_wait_timer #(
    parameter int MS_W = 16
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  wire logic            start,
    input  wire logic [MS_W-1:0] waitMs,
    output logic                 busy
);
    logic [17:0]     cycCnt_q, cycCnt_d;
    logic [MS_W-1:0] msCnt_q, msCnt_d;
    logic            busy_d;

    always_comb begin
        cycCnt_d = cycCnt_q;
        msCnt_d  = msCnt_q;
        busy_d   = busy;
        if (start) begin
            cycCnt_d = '0;
            msCnt_d  = waitMs;
            busy_d   = (waitMs != '0);
        end else if (busy) begin
            if (cycCnt_q == 18'(`CYCLES_PER_MS - 1)) begin
                cycCnt_d = '0;
                msCnt_d  = msCnt_q - 1'b1;
                busy_d   = (msCnt_q != {{(MS_W-1){1'b0}}, 1'b1});
            end else begin
                cycCnt_d = cycCnt_q + 18'h00001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cycCnt_q <= '0;
            msCnt_q  <= '0;
            busy     <= 1'b0;
        end else begin
            cycCnt_q <= cycCnt_d;
            msCnt_q  <= msCnt_d;
            busy     <= busy_d;
        end
    end
endmodule // switch_wait_timer
